//--- dv/mwrr_host_model.sv
// Purpose: host controller issuing apb transfers
// Assumes: slave may insert wait states
// Notes: tasks are called by the bench
`default_nettype none

module mwrr_host_model
  import mwrr_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // apb master side
  output mwrr_apb_req_t apb_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial apb_o = '0;

  // ==========================================================
  // one transfer, held until pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    logic ok;
    @(posedge sys_clk_i);
    apb_o <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge sys_clk_i);
    apb_o.penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      ok = pready_i;
      rd = prdata_i;
      err = pslverr_i;
    end while (ok !== 1'b1);
    apb_o.psel <= 1'b0;
    apb_o.penable <= 1'b0;
  endtask : xfer
endmodule : mwrr_host_model

`default_nettype wire

//--- dv/mwrr_readout_assertions.sv
// Purpose: port checks for the readout block
// Assumes: host follows apb setup/access order
// Notes: bound to every mwrr_readout instance
`default_nettype none

module mwrr_readout_assertions
  import mwrr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // observed ports
  input wire mwrr_apb_req_t apb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic pwr_valid_o,
  input wire logic irq_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rs_rd;
  logic en_wr;
  logic bad_a;

  // ==========================================================
  // helpers
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  assign rs_rd = apb_i.psel && apb_i.penable && !apb_i.pwrite && pready_o &&
                 apb_i.paddr == MWRR_OFS_RST_STATUS;
  assign en_wr = apb_i.psel && apb_i.penable && apb_i.pwrite &&
                 apb_i.paddr == MWRR_OFS_IRQ_EN;
  assign bad_a = apb_i.paddr > MWRR_OFS_VOLT_RMS_OS || apb_i.paddr[1:0] != 2'h0;

  // ==========================================================
  // checks
  AST_RDY_SETUP: assert property (apb_i.psel && !apb_i.penable |=> pready_o)
    else $error("no ready after setup");
  AST_RDY_IDLE: assert property (!apb_i.psel |-> !pready_o)
    else $error("ready while idle");
  AST_RDAT_ZERO: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside access");
  AST_ERR_MAP: assert property (pready_o && bad_a |-> pslverr_o)
    else $error("no error on unmapped address");
  AST_ERR_OK: assert property (pready_o && !bad_a |-> !pslverr_o)
    else $error("error on mapped address");
  AST_UPPER_ZERO: assert property (pready_o |-> prdata_o[31:24] == 8'h00)
    else $error("read data not right justified");
  AST_PWR_RATE: assert property (
    pwr_valid_o |=> !pwr_valid_o [*3] ##1 pwr_valid_o)
    else $error("power path not every fourth cycle");
  AST_IRQ_RISE: assert property (
    $rose(irq_b_o) |-> $past(rs_rd, 2) || $past(en_wr, 2) || !$past(rst_b_i))
    else $error("irq released without status read");

  cover property (rs_rd);
  cover property ($fell(irq_b_o));
  cover property (pready_o && pslverr_o);
endmodule : mwrr_readout_assertions

bind mwrr_readout mwrr_readout_assertions mwrr_readout_assertions_i (.sys_clk_i,
  .rst_b_i, .apb_i, .prdata_o, .pready_o, .pslverr_o, .pwr_valid_o, .irq_b_o);

`default_nettype wire

//--- dv/test_metering_waveform_rms_readout.sv
// Purpose: self-checking bench for the readout block
// Assumes: 50 ns clock, short filter shifts
// Notes: host model drives the apb port
`default_nettype none

`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end

module test_metering_waveform_rms_readout;
  import mwrr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  mwrr_apb_req_t apb_i;
  mwrr_adc_t adc_i = '0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [23:0] pwr_cur_o;
  logic [15:0] pwr_volt_o;
  logic pwr_valid_o;
  logic irq_b_o;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  logic [31:0] rd;
  logic [31:0] w0;
  logic er;

  mwrr_readout #(.LPF_SHIFT(4), .RMS_SHIFT(4)) mwrr_readout_i (.sys_clk_i, .rst_b_i,
    .apb_i, .prdata_o, .pready_o, .pslverr_o, .adc_i, .pwr_cur_o, .pwr_volt_o,
    .pwr_valid_o, .irq_b_o);
  mwrr_host_model mwrr_host_model_i (.sys_clk_i, .apb_o(apb_i), .prdata_i(prdata_o),
    .pready_i(pready_o), .pslverr_i(pslverr_o));

  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] md(input logic [1:0] s, input logic [1:0] r,
                                     input logic [2:0] g);
    return {17'h0, s, r, g, 8'h00};
  endfunction : md
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mwrr_host_model_i.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdv(input logic [7:0] a);
    mwrr_host_model_i.xfer(1'b0, a, 32'h0, rd, er);
  endtask : rdv
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    rdv(a);
    `CHK(n, e, rd)
  endtask : rd_chk
  task automatic near(input string n, input logic [31:0] e, input logic [31:0] t);
    `CHK(n, 1'b1, (rd + t >= e) && (rd <= e + t))
  endtask : near
  task automatic set_adc(input logic [23:0] c, input logic [15:0] v);
    @(posedge sys_clk_i);
    adc_i <= '{c, v};
  endtask : set_adc
  task automatic clr();
    rdv(MWRR_OFS_RST_STATUS);
    repeat (2) @(negedge sys_clk_i);
    `CHK("irq_clear", 1'b1, irq_b_o)
  endtask : clr
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_b_o !== 1'b0 && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    `CHK("irq_low", 1'b0, irq_b_o)
  endtask : wait_irq
  task final_report();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ==========================================================
  // tests
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd_chk("mode", MWRR_OFS_MODE, 32'h0);
    rd_chk("irq_en", MWRR_OFS_IRQ_EN, 32'h0);
    rd_chk("cur_os", MWRR_OFS_CUR_RMS_OS, 32'h0);
    rd_chk("volt_os", MWRR_OFS_VOLT_RMS_OS, 32'h0);
    rd_chk("unmapped", 8'h24, 32'h0);
    `CHK("slverr", 1'b1, er)
    wr(MWRR_OFS_CUR_RMS, 32'h00abcdef);
    rd_chk("cur_rms_ro", MWRR_OFS_CUR_RMS, 32'h0);
    set_adc(MWRR_CUR_POS_LIM, MWRR_VOLT_NEG_LIM);
    wr(MWRR_OFS_IRQ_EN, 32'h8);
    wr(MWRR_OFS_MODE, md(2'h2, 2'h0, 3'h0));
    wait_irq();
    rd_chk("status", MWRR_OFS_STATUS, 32'h1);
    rd_chk("wave_pos", MWRR_OFS_WAVEFORM, 32'h002851ec);
    `CHK("pwr_cur", MWRR_CUR_POS_LIM, pwr_cur_o)
    clr();
    set_adc(MWRR_CUR_NEG_LIM, MWRR_VOLT_NEG_LIM);
    wait_irq();
    rd_chk("wave_neg", MWRR_OFS_WAVEFORM, 32'h00d7ae14);
    for (int r = 0; r < 4; r++) begin
      wr(MWRR_OFS_MODE, md(2'h2, 2'(r), 3'h0));
      clr();
      wait_irq();
      t0 = cyc;
      clr();
      wait_irq();
      `CHK("rate", 128 << r, cyc - t0)
    end
    wr(MWRR_OFS_MODE, md(2'h3, 2'h0, 3'h0));
    repeat (2000) @(posedge sys_clk_i);
    clr();
    wait_irq();
    rdv(MWRR_OFS_WAVEFORM);
    `CHK("wave_volt", 24'(signed'(MWRR_VOLT_NEG_LIM)), rd[23:0])
    set_adc(24'h0, MWRR_VOLT_POS_LIM);
    clr();
    wait_irq();
    rdv(MWRR_OFS_WAVEFORM);
    `CHK("lowpass", 1'b1, rd[23:0] != 24'h002852)
    `CHK("pwr_volt", MWRR_VOLT_POS_LIM, pwr_volt_o)
    wr(MWRR_OFS_IRQ_EN, 32'h0);
    rdv(MWRR_OFS_WAVEFORM);
    w0 = rd;
    set_adc(24'h0, 16'h0100);
    repeat (600) @(posedge sys_clk_i);
    rd_chk("wave_hold", MWRR_OFS_WAVEFORM, w0);
    for (int g = 0; g < 6; g++) begin
      wr(MWRR_OFS_MODE, md(2'h0, 2'h0, 3'(g)));
      repeat (12) @(negedge sys_clk_i);
      `CHK("gain", 16'h0100 << (g > 4 ? 4 : g), pwr_volt_o)
    end
    set_adc(24'h0, MWRR_VOLT_POS_LIM);
    repeat (12) @(negedge sys_clk_i);
    `CHK("gain_sat", 16'h7fff, pwr_volt_o)
    rd_chk("ovr", MWRR_OFS_STATUS, 32'h5);
    set_adc(24'h000400, 16'h0400);
    wr(MWRR_OFS_MODE, 32'h0);
    repeat (2000) @(posedge sys_clk_i);
    rdv(MWRR_OFS_CUR_RMS);
    w0 = rd;
    rdv(MWRR_OFS_CUR_RMS);
    rd = (rd + w0) >> 1;
    near("cur_rms", 32'd1024, 32'd8);
    rdv(MWRR_OFS_VOLT_RMS);
    near("volt_rms", 32'h040000, 32'h1000);
    w0 = rd;
    wr(MWRR_OFS_CUR_RMS_OS, 32'h020);
    wr(MWRR_OFS_VOLT_RMS_OS, 32'h7ff);
    repeat (2000) @(posedge sys_clk_i);
    rdv(MWRR_OFS_CUR_RMS);
    near("cur_os_pos", 32'd1448, 32'd8);
    rd_chk("vos_pos", MWRR_OFS_VOLT_RMS, w0 + 32'd2047);
    wr(MWRR_OFS_CUR_RMS_OS, 32'hfe0);
    wr(MWRR_OFS_VOLT_RMS_OS, 32'h800);
    repeat (2000) @(posedge sys_clk_i);
    rdv(MWRR_OFS_CUR_RMS);
    near("cur_os_neg", 32'd0, 32'd8);
    rd_chk("vos_neg", MWRR_OFS_VOLT_RMS, w0 - 32'd2048);
    rd_chk("cur_os_rw", MWRR_OFS_CUR_RMS_OS, 32'hfe0);
    final_report();
  end
endmodule : test_metering_waveform_rms_readout

`default_nettype wire

//--- logic/mwrr_pkg.sv
// Purpose: shared constants and types for the waveform and rms readout
// Assumes: 32-bit APB register bus, one clock (sys_clk_i)
// Notes: offsets are byte addresses, one aligned word per register
`default_nettype none

package mwrr_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] MWRR_OFS_MODE = 8'h00;
  localparam logic [7:0] MWRR_OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] MWRR_OFS_RST_STATUS = 8'h08;
  localparam logic [7:0] MWRR_OFS_STATUS = 8'h0c;
  localparam logic [7:0] MWRR_OFS_WAVEFORM = 8'h10;
  localparam logic [7:0] MWRR_OFS_CUR_RMS = 8'h14;
  localparam logic [7:0] MWRR_OFS_CUR_RMS_OS = 8'h18;
  localparam logic [7:0] MWRR_OFS_VOLT_RMS = 8'h1c;
  localparam logic [7:0] MWRR_OFS_VOLT_RMS_OS = 8'h20;

  // ==========================================================
  // field positions and reset values
  localparam int MWRR_MODE_SRC_LSB = 13;
  localparam int MWRR_MODE_RATE_LSB = 11;
  localparam int MWRR_MODE_GAIN_LSB = 8;
  localparam int MWRR_IRQ_EN_WAVE_BIT = 3;
  localparam logic [15:0] MWRR_MODE_RST = 16'h0000;
  localparam logic [7:0] MWRR_IRQ_EN_RST = 8'h00;
  localparam logic [11:0] MWRR_OS_RST = 12'h000;
  localparam logic [1:0] MWRR_SRC_CURRENT = 2'h2;
  localparam logic [1:0] MWRR_SRC_VOLTAGE = 2'h3;

  // ==========================================================
  // timing
  localparam int MWRR_MOD_DIV = 4;
  localparam int MWRR_WAVE_DIV_MIN = 128;
  localparam logic [2:0] MWRR_GAIN_MAX_SHIFT = 3'h4;

  // ==========================================================
  // nominal full-scale sample limits
  localparam logic [23:0] MWRR_CUR_POS_LIM = 24'h2851ec;
  localparam logic [23:0] MWRR_CUR_NEG_LIM = 24'hd7ae14;
  localparam logic [15:0] MWRR_VOLT_POS_LIM = 16'h2852;
  localparam logic [15:0] MWRR_VOLT_NEG_LIM = 16'hd7ae;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mwrr_apb_req_t;

  typedef struct packed {
    logic [23:0] cur_sample;
    logic [15:0] volt_sample;
  } mwrr_adc_t;

  typedef enum logic [1:0] {
    MWRR_ST_IDLE,
    MWRR_ST_ACCESS
  } mwrr_bus_st_t;

endpackage : mwrr_pkg

`default_nettype wire

//--- logic/mwrr_readout.sv
// Purpose: waveform sampling and rms measurement for current and voltage
// Assumes: adc words arrive on sys_clk_i, valid once every four cycles
// Notes: apb slave with zero wait states; irq_b_o is active low
//
// Notes on behaviour
// R1 - current samples signed 24-bit, max clk/128
// R2 - current full scale near 0x2851ec/0xd7ae14
// R3 - source 1,0 routes current to waveform
// R4 - source 1,1 plus enable routes voltage
// R5 - host sets waveform interrupt enable bit 3
// R6 - power path keeps running during sampling
// R7 - rate field bits 12:11 picks four rates
// R8 - new sample drives interrupt low
// R9 - interrupt low until reset-status read
// R10 - 24-bit sample right justified, msb first
// R11 - current rms unsigned 24-bit, sample lsb
// R12 - both rms results update at clk/4
// R13 - current offset: sqrt(rms^2 + os*32768)
// R14 - voltage sample 16-bit sign extended
// R15 - voltage full scale near 0x2852/0xd7ae
// R16 - 140 Hz lowpass before waveform and rms only
// R17 - power path takes unfiltered voltage
// R18 - voltage gain 1, 2, 4, 8, 16
// R19 - voltage rms from filtered samples, 24-bit
// R20 - voltage offset added directly to rms
// R21 - host reads rms at zero crossings
// R22 - square, average, root, then offset; current offset before root
`default_nettype none

module mwrr_readout
  import mwrr_pkg::*;
#(
  parameter int LPF_SHIFT = 13,
  parameter int RMS_SHIFT = 12
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire mwrr_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // adc words
  input wire mwrr_adc_t adc_i,
  // power path
  output logic [23:0] pwr_cur_o,
  output logic [15:0] pwr_volt_o,
  output logic pwr_valid_o,
  // interrupt request
  output logic irq_b_o
);

  // ==========================================================
  // functions
  function automatic logic [23:0] mwrr_isqrt(input logic [47:0] v);
    logic [23:0] r;
    logic [23:0] t;
    logic [47:0] p;
    r = '0;
    for (int i = 23; i >= 0; i--) begin
      t = r | (24'h000001 << i);
      p = {24'h000000, t} * {24'h000000, t};
      if (p <= v) begin
        r = t;
      end
    end
    return r;
  endfunction : mwrr_isqrt

  function automatic logic [15:0] mwrr_gain(input logic [15:0] x, input logic [2:0] sh);
    logic signed [31:0] w;
    w = 32'(signed'(x)) <<< sh;
    if (w > 32'sh00007fff) begin
      return 16'h7fff;
    end else if (w < -32'sh00008000) begin
      return 16'h8000;
    end else begin
      return w[15:0];
    end
  endfunction : mwrr_gain

  function automatic logic [23:0] mwrr_clamp24(input logic signed [49:0] v);
    if (v < 50'sh0) begin
      return 24'h000000;
    end else if (v > 50'sh0000000ffffff) begin
      return 24'hffffff;
    end else begin
      return v[23:0];
    end
  endfunction : mwrr_clamp24

  // ==========================================================
  // registers
  logic [15:0] mode_r;
  logic [7:0] irq_en_r;
  logic [11:0] cur_os_r;
  logic [11:0] volt_os_r;
  logic [23:0] wave_r;
  logic [23:0] cur_rms_r;
  logic [23:0] volt_rms_r;
  logic wave_flag_r;
  logic cur_ovr_r;
  logic volt_ovr_r;
  logic [1:0] tick_cnt_r;
  logic [10:0] wave_cnt_r;
  logic [23:0] cur_s_r;
  logic [15:0] volt_s_r;
  logic signed [15+LPF_SHIFT:0] vlpf_acc_r;
  logic [47+RMS_SHIFT:0] cur_ms_r;
  logic [47+RMS_SHIFT:0] volt_ms_r;
  mwrr_bus_st_t bus_st_r;
  logic [31:0] rdata_r;
  logic err_r;

  // ==========================================================
  // decode
  logic [1:0] wave_src;
  logic [1:0] rate_sel;
  logic [2:0] gain_sel;
  logic wave_irq_en;
  logic tick;
  logic wave_tick;
  logic [10:0] wave_period;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_clear;
  logic new_sample;

  assign wave_src = mode_r[MWRR_MODE_SRC_LSB +: 2];
  assign rate_sel = mode_r[MWRR_MODE_RATE_LSB +: 2]; // [R7]
  assign gain_sel = mode_r[MWRR_MODE_GAIN_LSB +: 3];
  assign wave_irq_en = irq_en_r[MWRR_IRQ_EN_WAVE_BIT]; // [R5]
  assign tick = (tick_cnt_r == 2'(MWRR_MOD_DIV - 1));
  assign wave_period = 11'(MWRR_WAVE_DIV_MIN) << rate_sel; // [R1] [R7]
  assign wave_tick = (wave_cnt_r == wave_period - 11'h001);
  assign setup = apb_i.psel && !apb_i.penable;
  assign access = apb_i.psel && apb_i.penable;
  assign wr_en = access && apb_i.pwrite && !err_r;
  assign rd_clear = access && !apb_i.pwrite && (apb_i.paddr == MWRR_OFS_RST_STATUS);

  // ==========================================================
  // modulator-rate tick and waveform decimation
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= 2'h0;
    end else begin
      tick_cnt_r <= tick ? 2'h0 : tick_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wave_cnt_r <= 11'h000;
    end else if (wave_tick || wave_cnt_r >= wave_period) begin
      wave_cnt_r <= 11'h000;
    end else begin
      wave_cnt_r <= wave_cnt_r + 11'h001;
    end
  end

  // ==========================================================
  // sample capture and gain stage
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cur_s_r <= 24'h000000;
      volt_s_r <= 16'h0000;
    end else if (tick) begin
      cur_s_r <= adc_i.cur_sample; // [R1]
      volt_s_r <= mwrr_gain(adc_i.volt_sample,
                            (gain_sel > MWRR_GAIN_MAX_SHIFT) ? MWRR_GAIN_MAX_SHIFT
                                                              : gain_sel); // [R18]
    end
  end

  // full-scale excursion flags, cleared with the reset-status read
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cur_ovr_r <= 1'b0;
      volt_ovr_r <= 1'b0;
    end else begin
      if (tick && ($signed(cur_s_r) > $signed(MWRR_CUR_POS_LIM) ||
                   $signed(cur_s_r) < $signed(MWRR_CUR_NEG_LIM))) begin
        cur_ovr_r <= 1'b1; // [R2]
      end else if (rd_clear) begin
        cur_ovr_r <= 1'b0;
      end
      if (tick && ($signed(volt_s_r) > $signed(MWRR_VOLT_POS_LIM) ||
                   $signed(volt_s_r) < $signed(MWRR_VOLT_NEG_LIM))) begin
        volt_ovr_r <= 1'b1; // [R15]
      end else if (rd_clear) begin
        volt_ovr_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // power path, untouched by sampling or filtering
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pwr_cur_o <= 24'h000000;
      pwr_volt_o <= 16'h0000;
      pwr_valid_o <= 1'b0;
    end else begin
      pwr_valid_o <= tick; // [R6]
      if (tick) begin
        pwr_cur_o <= cur_s_r;
        pwr_volt_o <= volt_s_r; // [R17]
      end
    end
  end

  // ==========================================================
  // single-pole voltage lowpass, waveform and rms only
  logic signed [15:0] vlpf;
  assign vlpf = vlpf_acc_r[15+LPF_SHIFT:LPF_SHIFT];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      vlpf_acc_r <= '0;
    end else if (tick) begin
      vlpf_acc_r <= vlpf_acc_r + ($bits(vlpf_acc_r))'(signed'(volt_s_r))
                    - ($bits(vlpf_acc_r))'(vlpf); // [R16]
    end
  end

  // ==========================================================
  // waveform register and interrupt
  always_comb begin
    new_sample = 1'b0;
    if (wave_tick) begin
      if (wave_src == MWRR_SRC_CURRENT) begin
        new_sample = 1'b1; // [R3]
      end else if (wave_src == MWRR_SRC_VOLTAGE && wave_irq_en) begin
        new_sample = 1'b1; // [R4]
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wave_r <= 24'h000000;
    end else if (new_sample) begin
      if (wave_src == MWRR_SRC_CURRENT) begin
        wave_r <= cur_s_r; // [R3]
      end else begin
        wave_r <= {{8{vlpf[15]}}, vlpf}; // [R14] [R16]
      end
    end
  end

  // set wins over the clearing read
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wave_flag_r <= 1'b0;
    end else if (new_sample) begin
      wave_flag_r <= 1'b1; // [R8]
    end else if (rd_clear) begin
      wave_flag_r <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      irq_b_o <= 1'b1;
    end else begin
      irq_b_o <= !(wave_flag_r && wave_irq_en); // [R8] [R9]
    end
  end

  // ==========================================================
  // rms: square, average, root, offset; current offset before the root
  logic [47:0] cur_sq;
  logic [47:0] volt_sq;
  logic signed [23:0] volt_scaled;
  logic [47:0] cur_ms;
  logic [47:0] volt_ms;
  logic signed [49:0] cur_corr;
  logic [23:0] volt_root;

  assign cur_sq = 48'(signed'(cur_s_r) * signed'(cur_s_r)); // [R11] [R22]
  assign volt_scaled = {vlpf, 8'h00}; // [R19]
  assign volt_sq = 48'(volt_scaled * volt_scaled); // [R22]
  assign cur_ms = cur_ms_r[47+RMS_SHIFT:RMS_SHIFT];
  assign volt_ms = volt_ms_r[47+RMS_SHIFT:RMS_SHIFT];
  assign cur_corr = signed'({2'b00, cur_ms})
                    + (50'(signed'(cur_os_r)) <<< 15); // [R13]
  assign volt_root = mwrr_isqrt(volt_ms); // [R22]

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cur_ms_r <= '0;
      volt_ms_r <= '0;
    end else if (tick) begin
      cur_ms_r <= cur_ms_r + ($bits(cur_ms_r))'(cur_sq)
                  - ($bits(cur_ms_r))'(cur_ms); // [R22]
      volt_ms_r <= volt_ms_r + ($bits(volt_ms_r))'(volt_sq)
                   - ($bits(volt_ms_r))'(volt_ms); // [R22]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cur_rms_r <= 24'h000000;
      volt_rms_r <= 24'h000000;
    end else if (tick) begin
      cur_rms_r <= mwrr_isqrt(cur_corr < 50'sh0 ? 48'h0 : cur_corr[47:0]); // [R11] [R12] [R13]
      volt_rms_r <= mwrr_clamp24(signed'({26'h0, volt_root})
                                 + 50'(signed'(volt_os_r))); // [R12] [R19] [R20]
    end
  end

  // ==========================================================
  // apb slave
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      bus_st_r <= MWRR_ST_IDLE;
    end else begin
      case (bus_st_r)
        MWRR_ST_IDLE: bus_st_r <= setup ? MWRR_ST_ACCESS : MWRR_ST_IDLE;
        MWRR_ST_ACCESS: bus_st_r <= setup ? MWRR_ST_ACCESS : MWRR_ST_IDLE;
        default: bus_st_r <= MWRR_ST_IDLE;
      endcase
    end
  end

  // read data and error latched in the setup cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else if (setup) begin
      err_r <= 1'b0;
      case (apb_i.paddr)
        MWRR_OFS_MODE: rdata_r <= {16'h0000, mode_r};
        MWRR_OFS_IRQ_EN: rdata_r <= {24'h000000, irq_en_r};
        MWRR_OFS_RST_STATUS,
        MWRR_OFS_STATUS: rdata_r <= {29'h0, volt_ovr_r, cur_ovr_r, wave_flag_r};
        MWRR_OFS_WAVEFORM: rdata_r <= {8'h00, wave_r}; // [R10]
        MWRR_OFS_CUR_RMS: rdata_r <= {8'h00, cur_rms_r}; // [R11]
        MWRR_OFS_CUR_RMS_OS: rdata_r <= {20'h00000, cur_os_r};
        MWRR_OFS_VOLT_RMS: rdata_r <= {8'h00, volt_rms_r}; // [R19]
        MWRR_OFS_VOLT_RMS_OS: rdata_r <= {20'h00000, volt_os_r};
        default: begin
          rdata_r <= 32'h00000000;
          err_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mode_r <= MWRR_MODE_RST;
      irq_en_r <= MWRR_IRQ_EN_RST;
      cur_os_r <= MWRR_OS_RST;
      volt_os_r <= MWRR_OS_RST;
    end else if (wr_en) begin
      case (apb_i.paddr)
        MWRR_OFS_MODE: mode_r <= apb_i.pwdata[15:0];
        MWRR_OFS_IRQ_EN: irq_en_r <= apb_i.pwdata[7:0];
        MWRR_OFS_CUR_RMS_OS: cur_os_r <= apb_i.pwdata[11:0];
        MWRR_OFS_VOLT_RMS_OS: volt_os_r <= apb_i.pwdata[11:0];
        default: ;
      endcase
    end
  end

  assign pready_o = (bus_st_r == MWRR_ST_ACCESS) && access;
  assign prdata_o = pready_o ? rdata_r : 32'h00000000;
  assign pslverr_o = pready_o && err_r;

endmodule : mwrr_readout

`default_nettype wire
